/* File: verilog/irq_mask_low_pkg.sv */
/*
 * constants for the low event interrupt enable mask block.
 * assumes a 32-bit register reached through a simple word port.
 */
package irq_mask_low_pkg;
    localparam int          REG_WIDTH          = 32;
    localparam logic [15:0] MASK_LOW_ADDR      = 16'h0405;
    localparam logic [31:0] MASK_LOW_RESET     = 32'h0000_0000;
    localparam logic [31:0] MASK_LOW_WRITABLE  = 32'h03FF_FFFF;
    localparam int          BIT_ENERGY_UPDATE  = 0;
    localparam int          BIT_ACTIVE_SIGN_LO = 1;
    localparam int          BIT_REACT_SIGN_LO  = 4;
    localparam int          BIT_PULSE_POL_LO   = 7;
    localparam int          BIT_PULSE_EDGE_LO  = 11;
    localparam int          BIT_NEW_SAMPLES    = 15;
    localparam int          BIT_CAPTURE_STOP   = 16;
    localparam int          BIT_PAGE_FULL      = 17;
    localparam int          NUM_EVENTS         = 18;
endpackage

/* File: verilog/event_interrupt_enable_mask.sv */
/*
 * low half of the event interrupt enable mask with its event status flags.
 * assumes the register port is synchronous to ref_clk and the event inputs
 * are single-cycle strobes or synchronous levels from the metering core.
 */
// Function
// - bit 17 enables buffer page full interrupt
// - bit 16 enables capture stop interrupt
// - bits 14-11 enable pulse falling edge interrupts
// - bits 10-7 enable pulse polarity change interrupts
// - bits 6-4 enable reactive sign change interrupts
// - bits 3-1 enable active sign change interrupts
// - bit 0 enables energy update interrupt
`timescale 1ns/100ps
module event_interrupt_enable_mask
    import irq_mask_low_pkg::*;
#(
    parameter int PULSES = 4                    // energy pulse outputs
)(
    input  wire logic        ref_clk,           // device clock
    input  wire logic        resetn,            // synchronous reset, low active
    input  wire logic        clk_en,            // freezes all state while low
    input  wire logic [15:0] reg_addr,          // register address
    input  wire logic        reg_wr,            // write strobe
    input  wire logic        reg_rd,            // read strobe
    input  wire logic [31:0] reg_wdata,         // write data
    output logic      [31:0] reg_rdata,         // read data, registered
    input  wire logic        page_filled,       // enabled buffer page filled
    input  wire logic        capture_stopped,   // buffer stopped after trigger
    input  wire logic        new_samples,       // new waveform samples ready
    input  wire logic [3:0]  energy_pulse_out,  // pulse pins 4..1
    input  wire logic [3:0]  pulse_sign,        // sign of each pulse, 1 positive
    input  wire logic [2:0]  reactive_sign_chg, // phase c..a reactive sign change
    input  wire logic [2:0]  active_sign_chg,   // phase c..a active sign change
    input  wire logic        energy_updated,    // energy accumulators updated
    input  wire logic [NUM_EVENTS-1:0] status_clear, // write-one-to-clear of flags
    output logic [NUM_EVENTS-1:0] status_flags, // sticky event flags
    output logic             irq_n              // interrupt, active low
);
    // the mask has exactly four pulse channels, so other counts cannot be served
    if (PULSES != 4)
    begin : g_bad_pulses
        $error("event_interrupt_enable_mask serves exactly four pulse outputs");
    end
    if (NUM_EVENTS > REG_WIDTH)
    begin : g_bad_events
        $error("event flags do not fit the mask register");
    end

    // one address decode shared by the write path, the read path and the checks
    function automatic logic hits_mask(input logic [15:0] addr);
        return (addr == MASK_LOW_ADDR);
    endfunction

    logic [31:0]           mask_reg;
    logic [31:0]           mask_next;
    logic [NUM_EVENTS-1:0] flag_reg;
    logic [NUM_EVENTS-1:0] flag_next;
    logic [NUM_EVENTS-1:0] event_vec;
    logic [3:0]            pulse_prev_reg;
    logic [3:0]            sign_prev_reg;
    logic [31:0]           rdata_reg;
    wire  logic [3:0]      pulse_fall;
    wire  logic [3:0]      sign_flip;
    wire  logic [3:0]      sign_next;
    wire  logic            addr_hit;
    wire  logic            irq_active;

    assign addr_hit   = hits_mask(reg_addr);

    // every pulse pin gets the same falling-edge and polarity watcher
    for (genvar p = 0; p < PULSES; p++)
    begin : g_pulse
        assign pulse_fall[p] = pulse_prev_reg[p] & ~energy_pulse_out[p];
        // polarity is sampled on each pulse's falling edge so a flip is seen when the pulse ends
        assign sign_flip[p]  = pulse_fall[p] & (pulse_sign[p] ^ sign_prev_reg[p]);
        assign sign_next[p]  = pulse_fall[p] ? pulse_sign[p] : sign_prev_reg[p];
    end

    always_comb
    begin
        event_vec = '0;
        event_vec[BIT_PAGE_FULL]    = page_filled;
        event_vec[BIT_CAPTURE_STOP] = capture_stopped;
        event_vec[BIT_NEW_SAMPLES]  = new_samples;
        event_vec[BIT_PULSE_EDGE_LO +: 4]  = pulse_fall;
        event_vec[BIT_PULSE_POL_LO +: 4]   = sign_flip;
        event_vec[BIT_REACT_SIGN_LO +: 3]  = reactive_sign_chg;
        event_vec[BIT_ACTIVE_SIGN_LO +: 3] = active_sign_chg;
        event_vec[BIT_ENERGY_UPDATE]       = energy_updated;
    end

    // set beats clear so an event landing on the clear cycle survives
    assign flag_next  = (flag_reg & ~status_clear) | event_vec;
    assign mask_next  = (reg_wr && addr_hit) ? (reg_wdata & MASK_LOW_WRITABLE) : mask_reg;
    assign irq_active = |(flag_reg & mask_reg[NUM_EVENTS-1:0]);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            mask_reg       <= MASK_LOW_RESET;
            flag_reg       <= '0;
            pulse_prev_reg <= '0;
            sign_prev_reg  <= '0;
            rdata_reg      <= '0;
        end
        else if (clk_en)
        begin
            mask_reg       <= mask_next;
            flag_reg       <= flag_next;
            pulse_prev_reg <= energy_pulse_out;
            sign_prev_reg  <= sign_next;
            if (reg_rd)
                rdata_reg  <= addr_hit ? mask_reg : '0;
        end
    end

    assign reg_rdata    = rdata_reg;
    assign status_flags = flag_reg;
    assign irq_n        = ~irq_active;

    property p_mask_reset;
        @(posedge ref_clk) !resetn |=> (mask_reg == MASK_LOW_RESET);
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not cleared");

    property p_irq_follows;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && |(event_vec & mask_next[NUM_EVENTS-1:0])) |=> !irq_n;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

    property p_masked_quiet;
        @(posedge ref_clk) disable iff (!resetn)
        (mask_reg[NUM_EVENTS-1:0] == '0) |-> irq_n;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("irq while masked");

    property p_page_irq;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && page_filled && mask_reg[BIT_PAGE_FULL] && !(reg_wr && addr_hit))
        |=> !irq_n;
    endproperty
    a_page_irq: assert property (p_page_irq) else $error("page irq missing");

    property p_stop_flag;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && capture_stopped) |=> flag_reg[BIT_CAPTURE_STOP];
    endproperty
    a_stop_flag: assert property (p_stop_flag) else $error("stop flag missing");

    property p_samples_flag;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && new_samples) |=> flag_reg[BIT_NEW_SAMPLES];
    endproperty
    a_samples_flag: assert property (p_samples_flag) else $error("sample flag missing");

    property p_pulse_fall;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && $past(clk_en) && $past(resetn) && $fell(energy_pulse_out[0]))
        |=> flag_reg[BIT_PULSE_EDGE_LO];
    endproperty
    a_pulse_fall: assert property (p_pulse_fall) else $error("pulse edge missed");

    property p_pol_flag;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && sign_flip[0]) |=> flag_reg[BIT_PULSE_POL_LO];
    endproperty
    a_pol_flag: assert property (p_pol_flag) else $error("polarity flag missed");

    property p_react_flag;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && reactive_sign_chg[2]) |=> flag_reg[BIT_REACT_SIGN_LO + 2];
    endproperty
    a_react_flag: assert property (p_react_flag) else $error("reactive flag missed");

    property p_active_flag;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && active_sign_chg[0]) |=> flag_reg[BIT_ACTIVE_SIGN_LO];
    endproperty
    a_active_flag: assert property (p_active_flag) else $error("active flag missed");

    property p_energy_flag;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && energy_updated && status_clear[BIT_ENERGY_UPDATE])
        |=> flag_reg[BIT_ENERGY_UPDATE];
    endproperty
    a_energy_flag: assert property (p_energy_flag) else $error("energy flag lost");

    property p_pin4_fall;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && $past(clk_en) && $past(resetn) && $fell(energy_pulse_out[3]))
        |=> flag_reg[BIT_PULSE_EDGE_LO + 3];
    endproperty
    a_pin4_fall: assert property (p_pin4_fall) else $error("pin 4 edge missed");

    // masking only gates the line: the flag must still be recorded
    property p_masked_records;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && energy_updated && !mask_reg[BIT_ENERGY_UPDATE])
        |=> flag_reg[BIT_ENERGY_UPDATE];
    endproperty
    a_masked_records: assert property (p_masked_records) else $error("masked flag lost");

    property p_flag_clear;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && status_clear[BIT_PAGE_FULL] && !page_filled) |=> !flag_reg[BIT_PAGE_FULL];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_mask_write;
        @(posedge ref_clk) disable iff (!resetn)
        (clk_en && reg_wr && addr_hit)
        |=> (mask_reg == ($past(reg_wdata) & MASK_LOW_WRITABLE));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_frozen;
        @(posedge ref_clk) disable iff (!resetn)
        !clk_en |=> ($stable(flag_reg) && $stable(mask_reg));
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while frozen");

    c_irq_raise: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(irq_n));
    c_mask_write: cover property (@(posedge ref_clk) disable iff (!resetn) reg_wr && addr_hit);
    c_pol_flip: cover property (@(posedge ref_clk) disable iff (!resetn) |sign_flip);
    c_set_clear_clash: cover property (@(posedge ref_clk) disable iff (!resetn)
        energy_updated && status_clear[BIT_ENERGY_UPDATE]);
endmodule // event_interrupt_enable_mask

/* File: bench/host_model.sv */
/*
 * host side model that watches the interrupt line and counts assertions.
 * assumes irq_n is an active low level synchronous to ref_clk.
 */
`timescale 1ns/100ps
module host_model (
    input  wire logic       ref_clk,   // device clock
    input  wire logic       irq_n,     // interrupt from the device
    output logic      [7:0] irq_count  // assertions of irq_n seen
);
    logic       irq_n_reg = 1'b1;
    logic [7:0] count_reg = 8'h00;
    // the line is a level, so only a high-to-low step counts as a new request
    always @(posedge ref_clk)
    begin
        if (irq_n_reg && !irq_n)
            count_reg <= count_reg + 8'h01;
        irq_n_reg <= irq_n;
    end
    assign irq_count = count_reg;
endmodule // host_model

/* File: bench/event_interrupt_enable_mask_tb.sv */
/*
 * self-checking bench for the low event interrupt enable mask.
 * assumes inputs change at the falling edge and results settle by the next one.
 */
`timescale 1ns/100ps
module event_interrupt_enable_mask_tb;
    import irq_mask_low_pkg::*;
    logic        ref_clk = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic [15:0] reg_addr = 16'h0000, seed = 16'hF594;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, exp_rd = 32'h0, exp_mk = 32'h0;
    logic [17:0] strb = '0, status_clear = '0, status_flags, exp_fl = '0;
    logic [3:0]  pin = 4'h0, pulse_sign = 4'h0, sg = 4'h0;
    logic        irq_n;
    logic [7:0]  irq_count;
    logic [50:0] q[$];
    logic [50:0] exp_q;
    int          n_mismatch = 0, checks = 0;
    event        smp;
    event_interrupt_enable_mask event_interrupt_enable_mask_i (.ref_clk(ref_clk),
        .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .page_filled(strb[17]), .capture_stopped(strb[16]), .new_samples(strb[15]),
        .energy_pulse_out(pin), .pulse_sign(pulse_sign), .reactive_sign_chg(strb[6:4]),
        .active_sign_chg(strb[3:1]), .energy_updated(strb[0]),
        .status_clear(status_clear), .status_flags(status_flags), .irq_n(irq_n));
    host_model host_model_i (.ref_clk(ref_clk), .irq_n(irq_n), .irq_count(irq_count));
    initial forever #10 ref_clk = ~ref_clk;
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cyc();
        @(negedge ref_clk);
    endtask
    task automatic cmp(logic [50:0] e, logic [50:0] a);
        checks++;
        if (a !== e)
        begin
            n_mismatch++;
            $display("BAD %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic cmp_rd(logic [31:0] e, logic [31:0] a);
        cmp({19'h0_0000, e}, {19'h0_0000, a});
    endtask
    task automatic cmp_irq(logic e, logic a);
        cmp({50'h0, e}, {50'h0, a});
    endtask
    task automatic cmp_fl(logic [17:0] e, logic [17:0] a);
        cmp({33'h0, e}, {33'h0, a});
    endtask
    task automatic cmp_cnt(logic [7:0] e, logic [7:0] a);
        cmp({43'h0, e}, {43'h0, a});
    endtask
    task automatic note();
        q.push_back({exp_rd, (exp_fl & exp_mk[17:0]) == 18'h0, exp_fl});
        ->smp;
    endtask
    task automatic wr(logic [15:0] a, logic [31:0] d);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        cyc();
        reg_wr = 0;
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] e);
        {reg_addr, reg_rd} = {a, 1'b1};
        cyc();
        reg_rd = 0;
        exp_rd = e;
    endtask
    task automatic fire(int i);
        int k;
        k = (i < 11) ? i - 7 : i - 11;
        if (i >= 7 && i <= 14)
        begin
            pin[k] = 1;
            cyc();
            pulse_sign[k] = (i < 11) ? ~sg[k] : sg[k];
            pin[k] = 0;
            exp_fl[11 + k] = 1;
            sg[k] = pulse_sign[k];
        end
        else
            strb[i] = 1;
        exp_fl[i] = 1;
        cyc();
        strb = '0;
    endtask
    always @(smp)
    begin
        exp_q = q.pop_front();
        cmp_rd(exp_q[50:19], reg_rdata);
        cmp_irq(exp_q[18], irq_n);
        cmp_fl(exp_q[17:0], status_flags);
    end
    task automatic summarize();
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (8) cyc();
        resetn = 1;
        rd(MASK_LOW_ADDR, 32'h0);
        note();
        exp_mk = {lfsr(seed), lfsr(lfsr(seed))};
        wr(MASK_LOW_ADDR, exp_mk);
        exp_mk = exp_mk & MASK_LOW_WRITABLE;
        rd(MASK_LOW_ADDR, exp_mk);
        note();
        clk_en = 0;
        wr(MASK_LOW_ADDR, 32'h0);
        clk_en = 1;
        rd(MASK_LOW_ADDR + 16'h1, 32'h0);
        note();
        rd(MASK_LOW_ADDR, exp_mk);
        note();
        resetn = 0;
        cyc();
        resetn = 1;
        rd(MASK_LOW_ADDR, 32'h0);
        exp_mk = 32'h0;
        note();
        for (int i = 0; i < NUM_EVENTS; i++)
            for (int m = 0; m < 2; m++)
            begin
                exp_mk = m ? ~(32'h1 << i) & MASK_LOW_WRITABLE : 32'h1 << i;
                wr(MASK_LOW_ADDR, exp_mk);
                fire(i);
                note();
                status_clear = '1;
                cyc();
                status_clear = '0;
                exp_fl = '0;
                note();
            end
        wr(MASK_LOW_ADDR, 32'h0000_0001);
        exp_mk = 32'h0000_0001;
        // a frozen block must not take an event
        {clk_en, strb[BIT_ENERGY_UPDATE]} = 2'h1;
        cyc();
        {clk_en, strb} = {1'b1, 18'h0_0000};
        note();
        // an event on the clear cycle must survive it
        {strb[BIT_ENERGY_UPDATE], status_clear} = {1'b1, 18'h3_FFFF};
        cyc();
        {strb, status_clear} = 36'h0_0000_0000;
        exp_fl[BIT_ENERGY_UPDATE] = 1'b1;
        note();
        status_clear = 18'h3_FFFF;
        cyc();
        status_clear = 18'h0_0000;
        exp_fl = 18'h0_0000;
        note();
        cmp_cnt(8'h17, irq_count);
        summarize();
    end
endmodule // event_interrupt_enable_mask_tb
